/* File: rtl/emtc_core.sv */
// Exception mask and thread-mode control special registers of the core
`timescale 1ns/1ps
// Notes on behaviour
// - Interrupt disable bit 0 set blocks all configurable-priority exceptions.
// - Fault disable bit set blocks everything except the nonmaskable interrupt.
// - Leaving any handler but the nonmaskable one clears fault disable.
// - Nonzero threshold masks configurable-priority exceptions with priority value at or above it.
// - Threshold sits in bits 7:4; other bits reserved.
// - Larger priority value means lower urgency in threshold compares.
// - Control bit 2 flags live float context, checked on exception entry.
// - Control bit 1 picks main (0) or process (1) stack pointer.
// - In handler mode stack select reads zero and writes are ignored.
// - Handler mode always runs on the main stack pointer.
// - Entry and return sequences update control, stack select on return.
// - Control bit 0 gives thread privilege: 0 privileged, 1 unprivileged.
// - After reset thread mode uses the main stack pointer.
// - Process stack chosen by software write or matching return code.
// - Masks readable/writable by moves; state change sets/clears two bits.
// - Every exception except reset runs in handler mode.
module emtc_core (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_msr_valid,
  input wire logic [1:0] i_msr_sel,
  input wire logic [31:0] i_msr_data,
  input wire logic i_mrs_valid,
  input wire logic [1:0] i_mrs_sel,
  input wire logic i_cps_valid,
  input wire logic i_cps_target,
  input wire logic i_cps_disable,
  input wire logic i_exc_entry,
  input wire logic [8:0] i_exc_entry_num,
  input wire logic i_exception_return_code,
  input wire logic [31:0] i_exception_return_code_code,
  input wire logic i_fp_exec,
  input wire logic i_pend_valid,
  input wire logic i_pend_configurable,
  input wire logic [8:0] i_pend_num,
  input wire logic [3:0] i_pend_priority,
  output logic o_pend_allowed,
  output logic [31:0] o_mrs_data,
  output logic o_mrs_valid,
  output logic o_handler_mode,
  output logic [8:0] o_active_num,
  output logic o_use_process_sp,
  output logic o_thread_unprivileged,
  output logic o_fp_context_active,
  output logic o_preserve_fp_on_entry,
  output logic o_int_disable,
  output logic o_fault_disable,
  output logic [3:0] o_threshold
);
  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic rst_meta;
  logic rst_sync_n;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic int_disable;
  logic fault_disable;
  logic [3:0] threshold;
  logic thread_unpriv;
  logic stack_sel;
  logic fp_active;
  logic handler_mode;
  logic [8:0] active_num;
  logic ret_to_thread;
  logic ret_nmi;

  function automatic logic [3:0] threshold_field(input logic [31:0] word);
    threshold_field = word[emtc_pkg::THRESHOLD_MSB:emtc_pkg::THRESHOLD_LSB];
  endfunction

  assign ret_to_thread = i_exception_return_code_code[emtc_pkg::RET_THREAD_BIT];
  assign ret_nmi = (active_num == emtc_pkg::EXC_NUM_NMI);

  // ------------------------------------------------------------
  // Interrupt disable mask
  // ------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      int_disable <= emtc_pkg::RST_INT_DISABLE;
    end else if (i_msr_valid && i_msr_sel == emtc_pkg::SEL_INT_DISABLE) begin
      int_disable <= i_msr_data[emtc_pkg::INT_DISABLE_BIT];
    end else if (i_cps_valid && i_cps_target == emtc_pkg::CPS_TARGET_INT) begin
      int_disable <= i_cps_disable;
    end
  end

  // ------------------------------------------------------------
  // Fault disable mask
  // ------------------------------------------------------------
  // Software writes take precedence over the automatic clear on return;
  // the core never retires both in one cycle, so this order only matters
  // for a misbehaving pipeline.
  always_ff @(posedge i_mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      fault_disable <= emtc_pkg::RST_FAULT_DISABLE;
    end else if (i_msr_valid && i_msr_sel == emtc_pkg::SEL_FAULT_DISABLE) begin
      fault_disable <= i_msr_data[emtc_pkg::FAULT_DISABLE_BIT];
    end else if (i_cps_valid && i_cps_target == emtc_pkg::CPS_TARGET_FAULT) begin
      fault_disable <= i_cps_disable;
    end else if (i_exception_return_code && handler_mode && !ret_nmi) begin
      fault_disable <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Priority threshold
  // ------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      threshold <= emtc_pkg::RST_THRESHOLD;
    end else if (i_msr_valid && i_msr_sel == emtc_pkg::SEL_PRIO_THRESHOLD) begin
      threshold <= threshold_field(i_msr_data);
    end
  end

  // ------------------------------------------------------------
  // Processor mode and active exception
  // ------------------------------------------------------------
  // Only one level of nesting is tracked; a return lands in thread mode
  // when the return code says so, otherwise handler mode persists.
  always_ff @(posedge i_mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      handler_mode <= 1'b0;
      active_num <= 9'h000;
    end else if (i_exc_entry) begin
      handler_mode <= 1'b1;
      active_num <= i_exc_entry_num;
    end else if (i_exception_return_code) begin
      handler_mode <= !ret_to_thread;
      active_num <= 9'h000;
    end
  end

  // ------------------------------------------------------------
  // Thread-mode control
  // ------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      stack_sel <= emtc_pkg::RST_STACK_SEL;
    end else if (i_exception_return_code) begin
      stack_sel <= ret_to_thread && i_exception_return_code_code[emtc_pkg::RET_STACK_BIT];
    end else if (i_exc_entry) begin
      stack_sel <= 1'b0;
    end else if (i_msr_valid && i_msr_sel == emtc_pkg::SEL_THREAD_CONTROL && !handler_mode) begin
      stack_sel <= i_msr_data[emtc_pkg::CTRL_STACK_SEL_BIT];
    end
  end

  always_ff @(posedge i_mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      thread_unpriv <= emtc_pkg::RST_UNPRIV;
    end else if (i_msr_valid && i_msr_sel == emtc_pkg::SEL_THREAD_CONTROL) begin
      thread_unpriv <= i_msr_data[emtc_pkg::CTRL_UNPRIV_BIT];
    end
  end

  always_ff @(posedge i_mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      fp_active <= emtc_pkg::RST_FP_ACTIVE;
    end else if (i_exc_entry) begin
      fp_active <= 1'b0;
    end else if (i_exception_return_code) begin
      fp_active <= !i_exception_return_code_code[emtc_pkg::RET_NO_FP_BIT];
    end else if (i_msr_valid && i_msr_sel == emtc_pkg::SEL_THREAD_CONTROL) begin
      fp_active <= i_msr_data[emtc_pkg::CTRL_FP_ACTIVE_BIT];
    end else if (i_fp_exec) begin
      fp_active <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Special-register read port
  // ------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      o_mrs_data <= 32'h00000000;
      o_mrs_valid <= 1'b0;
    end else begin
      o_mrs_valid <= i_mrs_valid;
      o_mrs_data <= 32'h00000000;
      if (i_mrs_valid) begin
        unique case (i_mrs_sel)
          emtc_pkg::SEL_INT_DISABLE: o_mrs_data[emtc_pkg::INT_DISABLE_BIT] <= int_disable;
          emtc_pkg::SEL_FAULT_DISABLE: o_mrs_data[emtc_pkg::FAULT_DISABLE_BIT] <= fault_disable;
          emtc_pkg::SEL_PRIO_THRESHOLD: begin
            o_mrs_data[emtc_pkg::THRESHOLD_MSB:emtc_pkg::THRESHOLD_LSB] <= threshold;
          end
          emtc_pkg::SEL_THREAD_CONTROL: begin
            o_mrs_data[emtc_pkg::CTRL_UNPRIV_BIT] <= thread_unpriv;
            o_mrs_data[emtc_pkg::CTRL_STACK_SEL_BIT] <= stack_sel && !handler_mode;
            o_mrs_data[emtc_pkg::CTRL_FP_ACTIVE_BIT] <= fp_active;
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Activation gating and status outputs
  // ------------------------------------------------------------
  logic pend_allowed_raw;

  emtc_gate u_gate (
    .i_configurable(i_pend_configurable),
    .i_is_nmi(i_pend_num == emtc_pkg::EXC_NUM_NMI),
    .i_priority(i_pend_priority),
    .i_int_disable(int_disable),
    .i_fault_disable(fault_disable),
    .i_threshold(threshold),
    .o_allowed(pend_allowed_raw)
  );

  assign o_pend_allowed = i_pend_valid && pend_allowed_raw;

  assign o_handler_mode = handler_mode;
  assign o_active_num = active_num;
  assign o_use_process_sp = stack_sel && !handler_mode;
  assign o_thread_unprivileged = thread_unpriv && !handler_mode;
  assign o_fp_context_active = fp_active;
  assign o_preserve_fp_on_entry = fp_active;
  assign o_int_disable = int_disable;
  assign o_fault_disable = fault_disable;
  assign o_threshold = threshold;
endmodule

/* File: rtl/emtc_pkg.sv */
// Package: constants for the exception mask and thread control block
package emtc_pkg;
  // Special-register selector codes used on the special-register move port
  localparam logic [1:0] SEL_INT_DISABLE = 2'h0;
  localparam logic [1:0] SEL_FAULT_DISABLE = 2'h1;
  localparam logic [1:0] SEL_PRIO_THRESHOLD = 2'h2;
  localparam logic [1:0] SEL_THREAD_CONTROL = 2'h3;
  // Field positions
  localparam int INT_DISABLE_BIT = 0;
  localparam int FAULT_DISABLE_BIT = 0;
  localparam int THRESHOLD_LSB = 4;
  localparam int THRESHOLD_MSB = 7;
  localparam int THRESHOLD_WIDTH = 4;
  localparam int CTRL_UNPRIV_BIT = 0;
  localparam int CTRL_STACK_SEL_BIT = 1;
  localparam int CTRL_FP_ACTIVE_BIT = 2;
  // Reset values
  localparam logic RST_INT_DISABLE = 1'b0;
  localparam logic RST_FAULT_DISABLE = 1'b0;
  localparam logic [3:0] RST_THRESHOLD = 4'h0;
  localparam logic RST_UNPRIV = 1'b0;
  localparam logic RST_STACK_SEL = 1'b0;
  localparam logic RST_FP_ACTIVE = 1'b0;
  // Exception number of the nonmaskable interrupt
  localparam logic [8:0] EXC_NUM_NMI = 9'h002;
  // Return-code bit that selects the process stack on return to thread mode
  localparam int RET_STACK_BIT = 2;
  localparam int RET_THREAD_BIT = 3;
  localparam int RET_NO_FP_BIT = 4;
  // Change-processor-state target codes
  localparam logic CPS_TARGET_INT = 1'b0;
  localparam logic CPS_TARGET_FAULT = 1'b1;
  typedef enum logic [1:0] {EMTC_SEL_A, EMTC_SEL_B, EMTC_SEL_C, EMTC_SEL_D} emtc_unused_type;
endpackage

/* File: rtl/emtc_gate.sv */
// Activation gate: decides whether a pending exception may be activated
`timescale 1ns/1ps
module emtc_gate (
  input wire logic i_configurable,
  input wire logic i_is_nmi,
  input wire logic [3:0] i_priority,
  input wire logic i_int_disable,
  input wire logic i_fault_disable,
  input wire logic [3:0] i_threshold,
  output logic o_allowed
);
  logic blocked_int;
  logic blocked_fault;
  logic blocked_thr;

  always_comb begin
    blocked_int = i_int_disable && i_configurable;
    blocked_fault = i_fault_disable && !i_is_nmi;
    // Larger field value is lower urgency, so >= threshold is masked
    blocked_thr = (i_threshold != 4'h0) && i_configurable && (i_priority >= i_threshold);
    o_allowed = !(blocked_int || blocked_fault || blocked_thr);
  end
endmodule

/* File: test/emtc_core_sva.sv */
// Port-level assertion checker for the exception mask and thread control core
`timescale 1ns/1ps
module emtc_core_sva (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_msr_valid,
  input wire logic i_cps_valid,
  input wire logic i_mrs_valid,
  input wire logic [1:0] i_mrs_sel,
  input wire logic i_exc_entry,
  input wire logic [8:0] i_exc_entry_num,
  input wire logic i_exception_return_code,
  input wire logic [31:0] i_exception_return_code_code,
  input wire logic i_pend_valid,
  input wire logic i_pend_configurable,
  input wire logic [8:0] i_pend_num,
  input wire logic [3:0] i_pend_priority,
  input wire logic o_pend_allowed,
  input wire logic [31:0] o_mrs_data,
  input wire logic o_mrs_valid,
  input wire logic o_handler_mode,
  input wire logic [8:0] o_active_num,
  input wire logic o_use_process_sp,
  input wire logic o_fault_disable,
  input wire logic o_int_disable,
  input wire logic [3:0] o_threshold
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  AST_INT_BLOCK: assert property (i_pend_valid && i_pend_configurable && o_int_disable |-> !o_pend_allowed)
    else $error("interrupt disable did not block");
  AST_FAULT_BLOCK: assert property (i_pend_valid && o_fault_disable && i_pend_num != emtc_pkg::EXC_NUM_NMI |-> !o_pend_allowed)
    else $error("fault disable did not block");
  AST_THRESH: assert property (i_pend_valid && i_pend_configurable && o_threshold != 4'h0
    && i_pend_priority >= o_threshold |-> !o_pend_allowed)
    else $error("threshold did not block");
  // Only a plain return is checked; software writes in the same cycle take precedence
  AST_FAULT_CLR: assert property (i_exception_return_code && o_handler_mode && !i_msr_valid && !i_cps_valid
    && o_active_num != emtc_pkg::EXC_NUM_NMI |=> !o_fault_disable)
    else $error("fault disable kept after return");
  AST_RET_PSP: assert property (i_exception_return_code && i_exception_return_code_code[emtc_pkg::RET_THREAD_BIT]
    && i_exception_return_code_code[emtc_pkg::RET_STACK_BIT] |=> o_use_process_sp && !o_handler_mode)
    else $error("return did not select process stack");
  AST_ENTRY: assert property (i_exc_entry && !i_exception_return_code |=> o_handler_mode && o_active_num == $past(i_exc_entry_num))
    else $error("entry did not reach handler mode");
  AST_HANDLER_MSP: assert property (o_handler_mode |-> !o_use_process_sp)
    else $error("handler on process stack");
  AST_MRS_RSV: assert property (i_mrs_valid && i_mrs_sel == emtc_pkg::SEL_PRIO_THRESHOLD
    |=> o_mrs_valid && o_mrs_data[31:8] == 24'h0 && o_mrs_data[3:0] == 4'h0)
    else $error("threshold read wrong");
endmodule
bind emtc_core emtc_core_sva chk_u (.*);

/* File: test/emtc_core_tb.sv */
// Self-checking testbench for the exception mask and thread control core
`timescale 1ns/1ps
module emtc_core_tb;
  logic i_mclk, i_reset_n, i_msr_valid, i_mrs_valid, i_cps_valid, i_cps_target, i_cps_disable, i_exc_entry;
  logic i_exception_return_code, i_fp_exec, i_pend_valid, i_pend_configurable, o_pend_allowed, o_mrs_valid, o_handler_mode;
  logic o_use_process_sp, o_thread_unprivileged, o_fp_context_active, o_preserve_fp_on_entry, o_int_disable;
  logic o_fault_disable;
  logic [1:0] i_msr_sel, i_mrs_sel;
  logic [31:0] i_msr_data, i_exception_return_code_code, o_mrs_data;
  logic [8:0] i_exc_entry_num, i_pend_num, o_active_num;
  logic [3:0] i_pend_priority, o_threshold;
  logic [31:0] exp_rd [4] = '{32'h1, 32'h1, 32'hF0, 32'h3};
  int fails = 0;
  int checked = 0;
  emtc_core dut_u (.*);
  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic write_special_reg_instr(input logic [1:0] sel, input logic [31:0] data);
    i_msr_sel = sel;
    i_msr_data = data;
    i_msr_valid = 1'b1;
    @(negedge i_mclk);
    i_msr_valid = 1'b0;
  endtask
  task automatic read_special_reg_instr(input logic [1:0] sel, input logic [31:0] exp);
    i_mrs_sel = sel;
    i_mrs_valid = 1'b1;
    @(negedge i_mclk);
    i_mrs_valid = 1'b0;
    chk(32'(o_mrs_valid), 32'h1);
    chk(o_mrs_data, exp);
  endtask
  task automatic change_processor_state_instr(input logic target, input logic value);
    i_cps_target = target;
    i_cps_disable = value;
    i_cps_valid = 1'b1;
    @(negedge i_mclk);
    i_cps_valid = 1'b0;
  endtask
  task automatic exc(input logic ret, input logic [8:0] num, input logic [31:0] code);
    i_exc_entry_num = num;
    i_exception_return_code_code = code;
    i_exc_entry = !ret;
    i_exception_return_code = ret;
    @(negedge i_mclk);
    {i_exc_entry, i_exception_return_code} = 2'b00;
  endtask
  // The gate is combinational, so it is looked at shortly after the candidate settles
  task automatic pend(input logic cfg, input logic [8:0] num, input logic [3:0] prio, input logic exp);
    {i_pend_valid, i_pend_configurable, i_pend_num, i_pend_priority} = {1'b1, cfg, num, prio};
    #1;
    chk(32'(o_pend_allowed), 32'(exp));
    // Realign so the next stimulus again changes on a falling edge
    @(negedge i_mclk);
  endtask
  // Tests need well under a hundred cycles; the limit leaves wide margin
  initial begin
    #20000;
    fails++;
    end_sim();
  end
  initial begin
    {i_msr_valid, i_mrs_valid, i_cps_valid, i_cps_target, i_cps_disable, i_exc_entry, i_exception_return_code} = '0;
    {i_fp_exec, i_pend_valid, i_pend_configurable, i_msr_sel, i_mrs_sel, i_msr_data, i_exception_return_code_code} = '0;
    {i_exc_entry_num, i_pend_num, i_pend_priority} = '0;
    i_reset_n = 1'b0;
    repeat (5) @(negedge i_mclk);
    i_reset_n = 1'b1;
    repeat (3) @(negedge i_mclk);
    for (int s = 0; s < 4; s++) read_special_reg_instr(s[1:0], 32'h0);
    chk(32'(o_use_process_sp), 32'h0);
    $display("test reset values done");
    for (int s = 0; s < 4; s++) begin
      write_special_reg_instr(s[1:0], 32'hFFFFFFFB);
      read_special_reg_instr(s[1:0], exp_rd[s]);
    end
    chk(32'(o_use_process_sp), 32'h1);
    chk(32'(o_thread_unprivileged), 32'h1);
    $display("test register access done");
    write_special_reg_instr(emtc_pkg::SEL_PRIO_THRESHOLD, 32'h0);
    change_processor_state_instr(emtc_pkg::CPS_TARGET_FAULT, 1'b0);
    pend(1'b1, 9'h010, 4'h0, 1'b0);
    pend(1'b0, 9'h003, 4'h0, 1'b1);
    change_processor_state_instr(emtc_pkg::CPS_TARGET_INT, 1'b0);
    pend(1'b1, 9'h010, 4'h0, 1'b1);
    change_processor_state_instr(emtc_pkg::CPS_TARGET_FAULT, 1'b1);
    pend(1'b0, 9'h003, 4'h0, 1'b0);
    pend(1'b0, emtc_pkg::EXC_NUM_NMI, 4'h0, 1'b1);
    change_processor_state_instr(emtc_pkg::CPS_TARGET_FAULT, 1'b0);
    write_special_reg_instr(emtc_pkg::SEL_PRIO_THRESHOLD, 32'h40);
    chk(32'(o_threshold), 32'h4);
    chk(32'(o_int_disable), 32'h0);
    pend(1'b1, 9'h010, 4'h4, 1'b0);
    pend(1'b1, 9'h010, 4'h5, 1'b0);
    pend(1'b1, 9'h010, 4'h3, 1'b1);
    write_special_reg_instr(emtc_pkg::SEL_PRIO_THRESHOLD, 32'h0);
    pend(1'b1, 9'h010, 4'hF, 1'b1);
    $display("test activation gate done");
    i_fp_exec = 1'b1;
    @(negedge i_mclk);
    i_fp_exec = 1'b0;
    chk(32'(o_fp_context_active), 32'h1);
    chk(32'(o_preserve_fp_on_entry), 32'h1);
    change_processor_state_instr(emtc_pkg::CPS_TARGET_FAULT, 1'b1);
    exc(1'b0, 9'h010, 32'h0);
    chk(32'(o_handler_mode), 32'h1);
    chk(32'(o_active_num), 32'h10);
    chk(32'(o_use_process_sp), 32'h0);
    write_special_reg_instr(emtc_pkg::SEL_THREAD_CONTROL, 32'h2);
    read_special_reg_instr(emtc_pkg::SEL_THREAD_CONTROL, 32'h0);
    exc(1'b1, 9'h0, 32'h1C);
    chk(32'({o_handler_mode, o_use_process_sp, o_fault_disable}), 32'h2);
    change_processor_state_instr(emtc_pkg::CPS_TARGET_FAULT, 1'b1);
    exc(1'b0, emtc_pkg::EXC_NUM_NMI, 32'h0);
    exc(1'b1, 9'h0, 32'h18);
    chk(32'({o_handler_mode, o_use_process_sp, o_fault_disable}), 32'h1);
    $display("test entry and return done");
    end_sim();
  end
endmodule
